// *** ctx_pkg.sv ***
// register map, field positions and constants of the camera tx control bank
package ctx_pkg;
  localparam logic [7:0] CTX_ADDR_TS_HIGH   = 8'h2c;
  localparam logic [7:0] CTX_ADDR_TS_LOW    = 8'h2d;
  localparam logic [7:0] CTX_ADDR_RSVD_LO   = 8'h2e;
  localparam logic [7:0] CTX_ADDR_RSVD_HI   = 8'h32;
  localparam logic [7:0] CTX_ADDR_CONTROL   = 8'h33;
  localparam logic [7:0] CTX_ADDR_CONTROL2  = 8'h34;
  localparam logic [7:0] CTX_ADDR_STATUS    = 8'h35;
  localparam logic [7:0] CTX_ADDR_EVENT     = 8'h37;
  localparam logic [7:0] CTX_ADDR_TS_STATUS = 8'h29;
  localparam logic [7:0] CTX_ADDR_TS_CTRL   = 8'h26;
  localparam logic [7:0] CTX_RSVD_VALUE     = 8'h00;
  localparam logic [7:0] CTX_CONTROL_RESET  = 8'h00;
  localparam logic [3:0] CTX_CONTROL2_UPPER = 4'h4;
  localparam int CTX_BIT_ENABLE     = 0;
  localparam int CTX_BIT_CONT_CLK   = 1;
  localparam int CTX_POS_LOW_POWER  = 2;
  localparam int CTX_POS_LANES      = 4;
  localparam int CTX_BIT_CAL_INIT   = 6;
  localparam int CTX_BIT_PERIODIC   = 0;
  localparam int CTX_BIT_SINGLE     = 1;
  localparam int CTX_BIT_INVERT     = 2;
  localparam int CTX_BIT_PASS_MODE  = 3;
  localparam int CTX_BIT_FREEZE     = 4;
  localparam int CTX_BIT_TIMESTAMP_READY_FLAG   = 4;
  localparam logic [1:0] CTX_LP_NORMAL = 2'h0;
  localparam logic [1:0] CTX_LP_DATA   = 2'h1;
  localparam logic [1:0] CTX_LP_ALL    = 2'h3;
  localparam logic [7:0] CTX_SKEW_PATTERN = 8'h55;
  // skew sequence length in link bytes
  localparam logic [7:0] CTX_SKEW_BYTES = 8'h10;
  typedef enum logic [2:0] {
    CTX_OFF   = 3'b000,
    CTX_INIT  = 3'b001,
    CTX_IDLE  = 3'b011,
    CTX_DATA  = 3'b010,
    CTX_SKEW  = 3'b110
  } ctx_state_t;
endpackage

// *** ctx_sync.sv ***
// two-flop synchroniser for signals from the link side
`timescale 1ns/10ps
module ctx_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      meta_reg <= '0;
      q        <= '0;
    end
    else if (ce)
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

// *** ctx_csi_tx_control.sv ***
// camera transmit port control and status register bank with lane sequencer
`timescale 1ns/10ps
// Behaviour
// - port 1 timestamp readable as two zero-reset read-only bytes
// - initial calibration enable sends skew sequence before any data
// - lane field: 00 four, 01 three, 10 two, 11 one lane
// - low power field: 00 normal, 01 data lanes, 11 all lanes
// - continuous clock runs once the first packet has arrived
// - enable bit gates the transmit outputs, but data_lp00 and clock_lp00 follow the low power field regardless
// - pass mode: any enabled port valid, or all enabled ports valid
// - skew pattern 01010101 from bit 0, inverted when invert set
// - single calibration goes at next idle then clears itself
// - periodic calibration follows every frame end sent
// - sync status reads one only while synchronising is enabled
// - unsynchronised pass shows delivery, cleared by error
// - synchronised pass shows only data available for delivery
// - pass rising edge latched in read-clear event bit
// - timestamp ready flag cleared when freeze bit is set
module ctx_csi_tx_control
  import ctx_pkg::*;
#(
  parameter int PORTS = 2
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             ce,
  input  wire logic [7:0]       addr,
  input  wire logic [7:0]       wdata,
  input  wire logic             wr,
  input  wire logic             rd,
  output logic      [7:0]       rdata,
  input  wire logic             link_clk,
  input  wire logic [PORTS-1:0] port_enable,
  input  wire logic [PORTS-1:0] port_valid,
  input  wire logic             sync_enable,
  input  wire logic             streams_aligned,
  input  wire logic             tx_error,
  input  wire logic             packet_valid,
  input  wire logic             frame_end,
  input  wire logic [15:0]      timestamp,
  input  wire logic             timestamp_done,
  output logic                  tx_active,
  output logic      [3:0]       lane_active,
  output logic      [3:0]       data_lp00,
  output logic                  clock_lp00,
  output logic                  clock_run,
  output logic                  data_send,
  output logic                  skew_send,
  output logic      [7:0]       skew_byte,
  output logic                  freeze
);
  ////////////////////////////////////////////////////////////////////////
  // link-side inputs pass two flops before use
  logic       lclk_s;
  logic [PORTS-1:0] en_s;
  logic [PORTS-1:0] val_s;
  logic [4:0] misc_s;
  logic [16:0] ts_s;
  ctx_sync #(.WIDTH(1 + 2 * PORTS + 5 + 17)) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .ce     (ce),
    .d      ({link_clk, port_enable, port_valid, sync_enable,
              streams_aligned, tx_error, packet_valid, frame_end,
              timestamp_done, timestamp}),
    .q      ({lclk_s, en_s, val_s, misc_s, ts_s})
  );
  logic sync_en;
  logic aligned;
  logic err;
  logic pkt;
  logic fend;
  assign {sync_en, aligned, err, pkt, fend} = misc_s;

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [6:0]  control_reg;
  logic [3:0]  control2_reg;
  logic [15:0] ts_reg;
  logic        timestamp_ready_flag_reg;
  logic        ts_done_d_reg;
  logic        freeze_reg;
  logic        pass_reg;
  logic        synced_reg;
  logic        pass_event_reg;
  logic        lclk_d_reg;
  logic        seen_packet_reg;
  logic        frame_end_d_reg;
  logic        periodic_pend_reg;
  logic [7:0]  skew_cnt_reg;
  logic        init_done_reg;
  ctx_state_t  state_reg;
  ctx_state_t  state_next;

  logic wr_ctl;
  logic wr_ctl2;
  logic wr_tsc;
  logic rd_event;
  logic link_edge;
  logic skew_done;
  assign wr_ctl    = wr && addr == CTX_ADDR_CONTROL;
  assign wr_ctl2   = wr && addr == CTX_ADDR_CONTROL2;
  assign wr_tsc    = wr && addr == CTX_ADDR_TS_CTRL;
  assign rd_event  = rd && addr == CTX_ADDR_EVENT;
  assign link_edge = lclk_s && !lclk_d_reg;
  assign skew_done = state_reg == CTX_SKEW && link_edge
                     && skew_cnt_reg == CTX_SKEW_BYTES - 8'h01;

  always_ff @(posedge clk)
  begin
    if (!resetn)
      control_reg <= CTX_CONTROL_RESET[6:0];
    else if (ce && wr_ctl)
      control_reg <= wdata[6:0];
  end

  // set on write, cleared after send
  always_ff @(posedge clk)
  begin
    if (!resetn)
      control2_reg <= 4'h0;
    else if (ce)
    begin
      if (wr_ctl2)
        // write of one merges with pending
        control2_reg <= {wdata[3:2], wdata[1] | control2_reg[1], wdata[0]};
      else if (skew_done && !periodic_pend_reg)
        control2_reg[CTX_BIT_SINGLE] <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      freeze_reg <= 1'b0;
    else if (ce && wr_tsc)
      freeze_reg <= wdata[CTX_BIT_FREEZE];
  end

  // ready set on capture, freeze clears it
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      ts_reg        <= 16'h0000;
      timestamp_ready_flag_reg  <= 1'b0;
      ts_done_d_reg <= 1'b0;
    end
    else if (ce)
    begin
      ts_done_d_reg <= ts_s[16];
      // one capture per done edge: the word is trusted only while the
      // source holds it still, not for as long as done stays high
      if (ts_s[16] && !ts_done_d_reg && !freeze_reg)
      begin
        ts_reg       <= ts_s[15:0];
        timestamp_ready_flag_reg <= 1'b1;
      end
      else if (wr_tsc && wdata[CTX_BIT_FREEZE])
        timestamp_ready_flag_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pass and sync status
  logic pass_next;
  logic any_ok;
  logic all_ok;
  always_comb
  begin
    any_ok = |(en_s & val_s);
    all_ok = (|en_s) && ((en_s & val_s) == en_s);
    // pass mode selects any or all
    pass_next = control2_reg[CTX_BIT_PASS_MODE] ? all_ok : any_ok;
    if (!sync_en && (err || !control_reg[CTX_BIT_ENABLE]))
      pass_next = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      pass_reg   <= 1'b0;
      synced_reg <= 1'b0;
    end
    else if (ce)
    begin
      pass_reg   <= pass_next;
      synced_reg <= sync_en && aligned;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      pass_event_reg <= 1'b0;
    else if (ce)
    begin
      if (pass_next && !pass_reg)
        pass_event_reg <= 1'b1;
      else if (rd_event)
        pass_event_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // link sequencer, stepped on link clock edges; a cleared enable bit drops it to off at once
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      lclk_d_reg      <= 1'b0;
      frame_end_d_reg <= 1'b0;
    end
    else if (ce)
    begin
      lclk_d_reg      <= lclk_s;
      frame_end_d_reg <= fend;
    end
  end

  // frame end queues a periodic sequence
  always_ff @(posedge clk)
  begin
    if (!resetn)
      periodic_pend_reg <= 1'b0;
    else if (ce)
    begin
      if (fend && !frame_end_d_reg && control2_reg[CTX_BIT_PERIODIC]
          && state_reg == CTX_DATA)
        periodic_pend_reg <= 1'b1;
      else if (skew_done)
        periodic_pend_reg <= 1'b0;
    end
  end

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      CTX_OFF:
        if (control_reg[CTX_BIT_ENABLE])
          state_next = CTX_INIT;
      CTX_INIT:
        if (control_reg[CTX_BIT_CAL_INIT] && !init_done_reg)
          state_next = CTX_SKEW;
        else
          state_next = CTX_IDLE;
      CTX_IDLE:
        if (periodic_pend_reg || control2_reg[CTX_BIT_SINGLE])
          state_next = CTX_SKEW;
        else if (pkt)
          state_next = CTX_DATA;
      CTX_DATA:
        if (!pkt)
          state_next = CTX_IDLE;
      CTX_SKEW:
        if (skew_done)
          state_next = CTX_IDLE;
      default:
        state_next = CTX_OFF;
    endcase
    if (!control_reg[CTX_BIT_ENABLE])
      state_next = CTX_OFF;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      state_reg <= CTX_OFF;
    else if (ce && (link_edge || state_next == CTX_OFF))
      state_reg <= state_next;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      init_done_reg <= 1'b0;
    else if (ce)
    begin
      if (!control_reg[CTX_BIT_ENABLE])
        init_done_reg <= 1'b0;
      else if (state_reg == CTX_INIT && link_edge)
        init_done_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      skew_cnt_reg <= 8'h00;
    else if (ce && link_edge)
      skew_cnt_reg <= (state_reg == CTX_SKEW) ? skew_cnt_reg + 8'h01 : 8'h00;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      seen_packet_reg <= 1'b0;
    else if (ce)
    begin
      if (state_reg == CTX_OFF)
        seen_packet_reg <= 1'b0;
      else if (pkt)
        seen_packet_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered lane outputs
  logic [1:0] lp_mode;
  logic [3:0] lanes_next;
  assign lp_mode = control_reg[CTX_POS_LOW_POWER +: 2];
  always_comb
  begin
    case (control_reg[CTX_POS_LANES +: 2])
      2'h0:    lanes_next = 4'hf;
      2'h1:    lanes_next = 4'h7;
      2'h2:    lanes_next = 4'h3;
      default: lanes_next = 4'h1;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      tx_active   <= 1'b0;
      lane_active <= 4'h0;
      data_lp00   <= 4'h0;
      clock_lp00  <= 1'b0;
      clock_run   <= 1'b0;
      data_send   <= 1'b0;
      skew_send   <= 1'b0;
      skew_byte   <= 8'h00;
      freeze      <= 1'b0;
    end
    else if (ce)
    begin
      tx_active   <= state_reg != CTX_OFF;
      lane_active <= control_reg[CTX_BIT_ENABLE] ? lanes_next : 4'h0;
      // forced lp00, reserved code acts as normal
      data_lp00   <= (lp_mode == CTX_LP_DATA || lp_mode == CTX_LP_ALL)
                     ? lanes_next : 4'h0;
      clock_lp00  <= lp_mode == CTX_LP_ALL;
      clock_run   <= control_reg[CTX_BIT_CONT_CLK] && seen_packet_reg
                     && state_reg != CTX_OFF;
      data_send   <= state_reg == CTX_DATA;
      skew_send   <= state_reg == CTX_SKEW;
      skew_byte   <= control2_reg[CTX_BIT_INVERT] ? ~CTX_SKEW_PATTERN
                                                   : CTX_SKEW_PATTERN;
      freeze      <= freeze_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read port, data one cycle after strobe
  always_ff @(posedge clk)
  begin
    if (!resetn)
      rdata <= 8'h00;
    else if (ce)
    begin
      rdata <= 8'h00;
      if (rd)
      begin
        case (addr)
          CTX_ADDR_TS_HIGH:   rdata <= ts_reg[15:8];
          CTX_ADDR_TS_LOW:    rdata <= ts_reg[7:0];
          CTX_ADDR_CONTROL:   rdata <= {1'b0, control_reg};
          CTX_ADDR_CONTROL2:  rdata <= {CTX_CONTROL2_UPPER, control2_reg};
          CTX_ADDR_STATUS:    rdata <= {6'h00, synced_reg, pass_reg};
          CTX_ADDR_EVENT:     rdata <= {7'h00, pass_event_reg};
          CTX_ADDR_TS_STATUS: rdata <= {3'h0, timestamp_ready_flag_reg, 4'h0};
          CTX_ADDR_TS_CTRL:   rdata <= {3'h0, freeze_reg, 4'h0};
          default:            rdata <= CTX_RSVD_VALUE;
        endcase
      end
    end
  end
endmodule

// *** ctx_csi_tx_control_asserts.sv ***
// checker for the camera tx control bank, bound to its ports
`timescale 1ns/10ps
module ctx_csi_tx_control_asserts
  import ctx_pkg::*;
(
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       ce,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic [3:0] lane_active,
  input wire logic [3:0] data_lp00,
  input wire logic       clock_lp00,
  input wire logic       data_send,
  input wire logic       skew_send,
  input wire logic [7:0] skew_byte,
  input wire logic       freeze
);
  logic [6:0] ctl_q;
  logic       inv_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // shadow of writes; outputs lag it, so checks wait two edges
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      ctl_q <= 7'h00;
      inv_q <= 1'b0;
    end
    else if (ce && wr && addr == CTX_ADDR_CONTROL)
      ctl_q <= wdata[6:0];
    else if (ce && wr && addr == CTX_ADDR_CONTROL2)
      inv_q <= wdata[CTX_BIT_INVERT];
  end
  chk_rd_idle: assert property (
    !$past(rd && ce) |-> rdata == 8'h00) else $error("rdata not idle");
  chk_lane_map: assert property (
    ctl_q == $past(ctl_q, 2) && ctl_q[0] |->
    lane_active == (4'hf >> ctl_q[5:4])) else $error("lane mask");
  chk_lp_data: assert property (
    ctl_q == $past(ctl_q, 2) && ctl_q[0] |->
    (|data_lp00) == ctl_q[2]) else $error("data lp00");
  chk_lp_clock: assert property (
    ctl_q == $past(ctl_q, 2) && ctl_q[0] |->
    clock_lp00 == (ctl_q[3:2] == 2'h3)) else $error("clock lp00");
  chk_off_lanes: assert property (
    ctl_q == $past(ctl_q, 2) && !ctl_q[0] |->
    lane_active == 4'h0) else $error("lanes while off");
  chk_skew_pat: assert property (
    skew_send && inv_q == $past(inv_q, 2) |->
    skew_byte == (inv_q ? 8'haa : 8'h55)) else $error("skew pattern");
  chk_send_excl: assert property (
    !(skew_send && data_send)) else $error("skew and data");
  chk_freeze_bit: assert property (
    ce && wr && addr == CTX_ADDR_TS_CTRL |-> ##2
    freeze == $past(wdata[CTX_BIT_FREEZE], 2)) else $error("freeze");
  chk_ctl_read: assert property (
    ce && rd && addr == CTX_ADDR_CONTROL |=>
    rdata == {1'b0, $past(ctl_q)}) else $error("control read");
  chk_ctl2_top: assert property (
    ce && rd && addr == CTX_ADDR_CONTROL2 |=>
    rdata[7:4] == 4'h4) else $error("control2 top");
  chk_rsvd_read: assert property (
    ce && rd && addr inside {[8'h2e:8'h32]} |=>
    rdata == 8'h00) else $error("reserved read");
endmodule
bind ctx_csi_tx_control ctx_csi_tx_control_asserts u_chk (
  .clk(clk), .resetn(resetn), .ce(ce), .wr(wr), .rd(rd), .addr(addr),
  .wdata(wdata), .rdata(rdata), .lane_active(lane_active),
  .data_lp00(data_lp00), .clock_lp00(clock_lp00), .data_send(data_send),
  .skew_send(skew_send), .skew_byte(skew_byte), .freeze(freeze));

// *** ctx_rx_model.sv ***
// downstream receiver model: link clock and skew burst counting
`timescale 1ns/10ps
module ctx_rx_model (
  output logic       link_clk,
  input  wire logic  skew_send,
  input  wire logic  data_send,
  output logic [7:0] bursts,
  output logic [7:0] len,
  output logic       data_first
);
  logic [7:0] cnt;
  initial
  begin
    link_clk = 1'b0;
    bursts = 8'h00;
    len = 8'h00;
    cnt = 8'h00;
    data_first = 1'b0;
  end
  always #200 link_clk = ~link_clk;
  always @(posedge link_clk)
  begin
    if (data_send && bursts == 8'h00 && cnt == 8'h00)
      data_first <= 1'b1;
    if (skew_send)
      cnt <= cnt + 8'h01;
    else if (cnt != 8'h00)
    begin
      len <= cnt;
      bursts <= bursts + 8'h01;
      cnt <= 8'h00;
    end
  end
endmodule

// *** tb_csi_tx_port_control_status.sv ***
// self-checking bench for the camera tx control bank
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_csi_tx_port_control_status
  import ctx_pkg::*;
;
  logic        clk, resetn, ce, wr, rd, link_clk, clock_lp00, freeze;
  logic        sync_enable, streams_aligned, tx_error, packet_valid;
  logic        frame_end, timestamp_done, tx_active, clock_run;
  logic        data_send, skew_send, data_first;
  logic [1:0]  port_enable, port_valid;
  logic [3:0]  lane_active, data_lp00;
  logic [7:0]  addr, wdata, rdata, skew_byte, bursts, len;
  logic [15:0] timestamp;
  logic [3:0]  lmask [4] = '{4'hf, 4'h7, 4'h3, 4'h1};
  logic [7:0]  ra [8] = '{8'h2c, 8'h2d, 8'h2e, 8'h32, 8'h33, 8'h34,
                          8'h35, 8'h50};
  int          errors = 0, checks_done = 0, cyc = 0;
  ctx_csi_tx_control #(.PORTS(2)) DUT (
    .clk(clk), .resetn(resetn), .ce(ce), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .link_clk(link_clk),
    .port_enable(port_enable), .port_valid(port_valid),
    .sync_enable(sync_enable), .streams_aligned(streams_aligned),
    .tx_error(tx_error), .packet_valid(packet_valid),
    .frame_end(frame_end), .timestamp(timestamp),
    .timestamp_done(timestamp_done), .tx_active(tx_active),
    .lane_active(lane_active), .data_lp00(data_lp00),
    .clock_lp00(clock_lp00), .clock_run(clock_run),
    .data_send(data_send), .skew_send(skew_send),
    .skew_byte(skew_byte), .freeze(freeze));
  ctx_rx_model u_rx (
    .link_clk(link_clk), .skew_send(skew_send), .data_send(data_send),
    .bursts(bursts), .len(len), .data_first(data_first));
  initial clk = 1'b0;
  always #25 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask
  // bounded wait, bursts take 16 link periods
  task automatic wait_b(input logic [7:0] n);
    int k;
    k = 0;
    while (bursts !== n && k < 4000)
    begin
      @(posedge clk);
      k++;
    end
    `CHK(bursts, n)
  endtask
  task automatic finish_test;
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      errors++;
      finish_test;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    {resetn, wr, rd, sync_enable, streams_aligned, tx_error} = '0;
    {packet_valid, frame_end, timestamp_done, addr, wdata} = '0;
    {port_enable, port_valid, timestamp} = '0;
    ce = 1'b1;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    foreach (ra[i])
      rd_chk(ra[i], ra[i] == 8'h34 ? 8'h40 : 8'h00);
    wr_reg(8'h2c, 8'hff);
    wr_reg(8'h30, 8'hff);
    rd_chk(8'h2c, 8'h00);
    rd_chk(8'h30, 8'h00);
    // data waiting before enable: calibration must still go first
    packet_valid <= 1'b1;
    wr_reg(8'h33, 8'hc3);
    rd_chk(8'h33, 8'h43);
    wait_b(8'h01);
    `CHK(len, CTX_SKEW_BYTES)
    `CHK(data_first, 1'b0)
    repeat (60) @(posedge clk);
    `CHK(data_send, 1'b1)
    `CHK(clock_run, 1'b1)
    packet_valid <= 1'b0;
    repeat (40) @(posedge clk);
    wr_reg(8'h34, 8'h06);
    wr_reg(8'h34, 8'h06);
    wait_b(8'h02);
    rd_chk(8'h34, 8'h44);
    repeat (300) @(posedge clk);
    `CHK(bursts, 8'h02)
    wr_reg(8'h34, 8'h01);
    packet_valid <= 1'b1;
    repeat (40) @(posedge clk);
    // frame end only counts while a packet is being sent
    frame_end <= 1'b1;
    repeat (8) @(posedge clk);
    {packet_valid, frame_end} <= 2'b00;
    wait_b(8'h03);
    `CHK(len, CTX_SKEW_BYTES)
    wr_reg(8'h34, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      wr_reg(8'h33, {2'h0, i[1:0], 4'h3}); // no replication here
      repeat (4) @(posedge clk);
      `CHK(lane_active, lmask[i])
    end
    for (int j = 0; j < 4; j++)
    begin
      wr_reg(8'h33, {4'h0, j[1:0], 2'h3});
      repeat (4) @(posedge clk);
      `CHK(|data_lp00, j[0])
      `CHK(clock_lp00, j == 3)
    end
    wr_reg(8'h33, 8'h00);
    repeat (40) @(posedge clk);
    `CHK(tx_active, 1'b0)
    `CHK(lane_active, 4'h0)
    wr_reg(8'h33, 8'h01);
    rd_chk(8'h37, 8'h00);
    port_enable <= 2'h3;
    port_valid <= 2'h1;
    repeat (8) @(posedge clk);
    rd_chk(8'h35, 8'h01);
    rd_chk(8'h37, 8'h01);
    rd_chk(8'h37, 8'h00);
    wr_reg(8'h34, 8'h08);
    repeat (4) @(posedge clk);
    rd_chk(8'h35, 8'h00);
    port_valid <= 2'h3;
    repeat (8) @(posedge clk);
    rd_chk(8'h35, 8'h01);
    tx_error <= 1'b1;
    repeat (8) @(posedge clk);
    rd_chk(8'h35, 8'h00);
    tx_error <= 1'b0;
    {sync_enable, streams_aligned} <= 2'b11;
    repeat (8) @(posedge clk);
    rd_chk(8'h35, 8'h03);
    sync_enable <= 1'b0;
    repeat (8) @(posedge clk);
    rd_chk(8'h35, 8'h01);
    timestamp <= 16'hbeef;
    timestamp_done <= 1'b1;
    repeat (8) @(posedge clk);
    rd_chk(8'h2c, 8'hbe);
    rd_chk(8'h2d, 8'hef);
    rd_chk(8'h29, 8'h10);
    wr_reg(8'h26, 8'h10);
    rd_chk(8'h29, 8'h00);
    `CHK(freeze, 1'b1)
    // clock enable low: a write must not land
    ce <= 1'b0;
    wr_reg(8'h33, 8'h00);
    ce <= 1'b1;
    rd_chk(8'h33, 8'h01);
    finish_test;
  end
endmodule
